/* File: src/mpps_map.svh */
// Widths, period defaults, phase counts and timing constants for the phase sequencer.
`ifndef MPPS_MAP_SVH
`define MPPS_MAP_SVH
`define MPPS_PERIOD_W        16
`define MPPS_PERIOD_DEFAULT  16'h0014
`define MPPS_PERIOD_MIN      16'h0004
`define MPPS_PHASES_MAX      4
`define MPPS_CNT_FOUR        3'h4
`define MPPS_CNT_THREE       3'h3
`define MPPS_CNT_TWO         3'h2
`define MPPS_STRAP_HOLD_NS   100
`define MPPS_CLK_NS          50
`define MPPS_STRAP_CYCLES    ((`MPPS_STRAP_HOLD_NS + `MPPS_CLK_NS - 1) / `MPPS_CLK_NS)
`endif

/* File: src/mpps_pkg.sv */
// Types for the multiphase phase sequencer.
package mpps_pkg;
  typedef enum logic [1:0] {
    MPPS_ST_STRAP,
    MPPS_ST_RUN
  } mpps_state_t;
endpackage : mpps_pkg

/* File: src/mpps_phase_slice.sv */
// One phase: sawtooth timebase, comparator and edge movement.
`timescale 1ns/100ps
`include "mpps_map.svh"
module mpps_phase_slice
  import mpps_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         i_clk,
  input  wire logic         i_rstn,
  input  wire logic         i_active,
  input  wire logic         i_sync,
  input  wire logic [W-1:0] i_period,
  input  wire logic [W-1:0] i_comp,
  input  wire logic [W-1:0] i_lead_shift,
  input  wire logic         i_all_on,
  output logic              o_pwm,
  output logic              o_cycle_end
);
  logic [W-1:0] ramp;
  logic [W-1:0] next_ramp;
  logic         pwm;
  logic         next_pwm;
  logic         done;
  logic         next_done;

  always_comb begin
    next_ramp = ramp;
    next_pwm  = pwm;
    next_done = done;
    if (!i_active) begin
      next_ramp = '0;
      next_pwm  = 1'b0;
      next_done = 1'b0;
    end else if (i_sync) begin
      // Cycle restarts at this phase's slot sync, not at its pulse termination. [R6]
      next_ramp = '0;
      next_done = 1'b0;
      next_pwm  = (i_lead_shift == '0); // [R10]
    end else begin
      if (ramp < i_period - W'(1)) begin
        next_ramp = ramp + W'(1);
      end
      // Leading edge moved later by a shift, trailing by the comparator. [R8]
      if (!done && ramp + W'(1) >= i_lead_shift && ramp + W'(1) < i_comp) begin
        next_pwm = 1'b1;
      end
      // Pulse ends where the sawtooth crosses the error signal. [R12]
      if (ramp + W'(1) >= i_comp) begin
        next_pwm  = 1'b0;
        next_done = 1'b1;
      end
    end
    if (i_active && i_all_on) begin
      next_pwm = 1'b1; // [R9]
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ramp <= '0;
      pwm  <= 1'b0;
      done <= 1'b0;
    end else begin
      ramp <= next_ramp;
      pwm  <= next_pwm;
      done <= next_done;
    end
  end

  assign o_pwm       = pwm;
  assign o_cycle_end = i_sync;
endmodule : mpps_phase_slice

/* File: src/mpps_sequencer.sv */
// Multiphase sequencer: phase count strapping and interleaved firing.
// Contract
// (R1) Active phases are spaced evenly across one switching period; the code gives the period remainder to the last slot.
// (R2) Four phases fire four, three, two, one, a quarter period apart.
// (R3) Fourth pin strapped high: three phases, three-two-one, third period.
// (R4) Third pin strapped high: two phases, second half period after first.
// (R5) Without strapping all four phases run.
// (R6) Each phase cycle runs between its own pulse terminations; the code restarts it at each slot sync instead.
// (R7) Switching period is fixed by external setting, never by transients.
// (R8) Leading and trailing edges of each pulse move independently.
// (R9) A large load step may turn all active phases on together.
// (R10) In steady state pulses start fixed and end variably.
// (R11) Inactive phases have current-sense disabled and no balancing.
// (R12) Each pulse comes from error signal versus its own sawtooth.
// (R13) Straps sampled once after reset; strapped pins never driven.
`timescale 1ns/100ps
`include "mpps_map.svh"
module mpps_sequencer
  import mpps_pkg::*;
#(
  parameter int W = `MPPS_PERIOD_W
) (
  input  wire logic         i_clk,
  input  wire logic         i_rstn,
  input  wire logic [W-1:0] i_frequency_set_input,
  input  wire logic [W-1:0] i_comp,
  input  wire logic [W-1:0] i_lead_shift,
  input  wire logic         i_all_phase_turn_on,
  input  wire logic         i_phase_out_three,
  input  wire logic         i_phase_out_four,
  output logic              o_phase_out_one,
  output logic              o_phase_out_two,
  output logic              o_phase_out_three,
  output logic              o_phase_out_four,
  output logic              o_phase_out_three_oe,
  output logic              o_phase_out_four_oe,
  output logic [3:0]        o_current_sense_en,
  output logic [2:0]        o_phase_count,
  output logic              o_running
);
  localparam logic [1:0] STRAP_CYC = 2'(`MPPS_STRAP_CYCLES);

  mpps_state_t state;
  mpps_state_t next_state;
  logic [1:0]   strap_cnt;
  logic [1:0]   next_strap_cnt;
  logic [2:0]   nph;
  logic [2:0]   next_nph;
  logic [W-1:0] period;
  logic [W-1:0] next_period;
  logic [W-1:0] tick;
  logic [W-1:0] next_tick;
  logic [1:0]   slot;
  logic [1:0]   next_slot;
  logic [W-1:0] slot_len;
  logic [3:0]   active;
  logic [3:0]   sync;
  logic [3:0]   pwm;
  logic [W-1:0] period_req;
  logic [1:0]   last_slot;
  logic [W-1:0] last_len;
  logic         slot_end;
  logic         cycle_end;
  logic [1:0]   fire_idx;
  logic [3:0]   sense_en;
  logic [3:0]   next_sense_en;

  // A period too short to give every phase a slot falls back to the
  // default instead of collapsing slots to zero length.
  assign period_req = (i_frequency_set_input < W'(`MPPS_PERIOD_MIN)) ?
                      W'(`MPPS_PERIOD_DEFAULT) : i_frequency_set_input;

  always_comb begin
    next_state     = state;
    next_strap_cnt = strap_cnt;
    next_nph       = nph;
    next_period    = period;
    case (state)
      MPPS_ST_STRAP: begin
        // Pins are read only while every output enable is low, so this
        // block never mistakes its own drive for a strap.
        // Pins settle for a short hold, then are latched once. [R13]
        if (strap_cnt == STRAP_CYC) begin
          next_state = MPPS_ST_RUN;
          if (i_phase_out_three) begin
            next_nph = `MPPS_CNT_TWO; // [R4]
          end else if (i_phase_out_four) begin
            next_nph = `MPPS_CNT_THREE; // [R3]
          end else begin
            next_nph = `MPPS_CNT_FOUR; // [R5]
          end
          // Period latched once so transients cannot shift frequency. [R7]
          next_period = period_req;
        end else begin
          next_strap_cnt = strap_cnt + 2'h1;
        end
      end
      MPPS_ST_RUN: begin
        next_state = MPPS_ST_RUN;
      end
      default: begin
        next_state = MPPS_ST_STRAP;
      end
    endcase
  end

  // Slot length is period over phase count; remainder goes to last slot.
  assign slot_len = period / W'(nph);
  assign last_slot = 2'(nph - 3'h1);
  assign last_len  = period - slot_len * W'(nph - 3'h1);
  assign slot_end  = (tick == slot_len - W'(1)) && (slot != last_slot);
  assign cycle_end = (tick == last_len - W'(1)) && (slot == last_slot);

  always_comb begin
    next_tick = tick;
    next_slot = slot;
    if (state == MPPS_ST_RUN) begin
      if (slot_end) begin
        next_tick = '0;
        next_slot = slot + 2'h1;
      end else if (cycle_end) begin // [R7]
        next_tick = '0;
        next_slot = 2'h0;
      end else begin
        next_tick = tick + W'(1);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state     <= MPPS_ST_STRAP;
      strap_cnt <= 2'h0;
      nph       <= `MPPS_CNT_FOUR;
      period    <= W'(`MPPS_PERIOD_DEFAULT);
      tick      <= '0;
      slot      <= 2'h0;
    end else begin
      state     <= next_state;
      strap_cnt <= next_strap_cnt;
      nph       <= next_nph;
      period    <= next_period;
      tick      <= next_tick;
      slot      <= next_slot;
    end
  end

  always_comb begin
    active = 4'h0;
    if (state == MPPS_ST_RUN) begin
      active[0] = 1'b1;
      active[1] = 1'b1;
      active[2] = (nph != `MPPS_CNT_TWO);
      active[3] = (nph == `MPPS_CNT_FOUR);
    end
  end

  // Sense enables are registered from the next strap result so that they
  // rise with the running state and never glitch while the count is
  // decoded; channels of unused phases stay out of current balance. [R11]
  always_comb begin
    next_sense_en = 4'h0;
    if (next_state == MPPS_ST_RUN) begin
      next_sense_en[0] = 1'b1;
      next_sense_en[1] = 1'b1;
      next_sense_en[2] = (next_nph != `MPPS_CNT_TWO);
      next_sense_en[3] = (next_nph == `MPPS_CNT_FOUR);
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sense_en <= 4'h0;
    end else begin
      sense_en <= next_sense_en;
    end
  end

  // Slot k starts the highest active phase minus k, giving the firing
  // order descending from it to phase one, equal slots except the remainder in the last. [R1] [R2] [R3] [R4]
  assign fire_idx = last_slot - slot;

  always_comb begin
    sync = 4'h0;
    if (state == MPPS_ST_RUN && tick == '0) begin
      sync[fire_idx] = 1'b1;
    end
  end

  // Every slice shares one error level and lead shift; per-phase trims
  // for current balance would enter here as separate compare words.
  genvar g;
  generate
    for (g = 0; g < `MPPS_PHASES_MAX; g++) begin : g_phase
      mpps_phase_slice #(.W(W)) u_slice (
        .i_clk        (i_clk),
        .i_rstn       (i_rstn),
        .i_active     (active[g]),
        .i_sync       (sync[g]),
        .i_period     (period),
        .i_comp       (i_comp),
        .i_lead_shift (i_lead_shift),
        .i_all_on     (i_all_phase_turn_on),
        .o_pwm        (pwm[g]),
        .o_cycle_end  ()
      );
    end
  endgenerate

  assign o_phase_out_one   = pwm[0];
  assign o_phase_out_two   = pwm[1];
  assign o_phase_out_three = pwm[2];
  assign o_phase_out_four  = pwm[3];
  // A strapped pin is tied to supply, so driving it would fight the tie.
  assign o_phase_out_three_oe = active[2]; // [R13]
  assign o_phase_out_four_oe  = active[3]; // [R13]
  assign o_current_sense_en   = sense_en; // [R11]
  assign o_phase_count        = nph;
  assign o_running            = (state == MPPS_ST_RUN);
endmodule : mpps_sequencer

/* File: verification/mpps_seq_asserts.sv */
// Checker for the phase sequencer ports.
`timescale 1ns/100ps
module mpps_seq_asserts (
  input wire logic       i_clk,
  input wire logic       i_rstn,
  input wire logic       i_all_phase_turn_on,
  input wire logic       i_phase_out_three,
  input wire logic       i_phase_out_four,
  input wire logic       o_phase_out_one,
  input wire logic       o_phase_out_two,
  input wire logic       o_phase_out_four,
  input wire logic       o_phase_out_three_oe,
  input wire logic       o_phase_out_four_oe,
  input wire logic [3:0] o_current_sense_en,
  input wire logic [2:0] o_phase_count,
  input wire logic       o_running
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  a_strap_count: assert property ($rose(o_running) |-> o_phase_count ==
    (i_phase_out_three ? 3'h2 : i_phase_out_four ? 3'h3 : 3'h4))
    else $error("phase count differs from straps");
  a_run_start: assert property (disable iff (1'b0)
    $rose(i_rstn) |-> ##[1:3] o_running) else $error("straps not latched");
  a_count_held: assert property (o_running && $past(o_running)
    |-> $stable(o_phase_count)) else $error("phase count changed");
  a_sense_map: assert property (o_running |-> o_current_sense_en ==
    4'hF >> (3'h4 - o_phase_count)) else $error("sense enables wrong");
  a_oe_four_off: assert property (o_running && o_phase_count != 3'h4
    |-> !o_phase_out_four_oe) else $error("strapped pin four driven");
  a_oe_three_off: assert property (o_running && o_phase_count == 3'h2
    |-> !o_phase_out_three_oe) else $error("strapped pin three driven");
  a_oe_full: assert property (o_running && o_phase_count == 3'h4
    |-> o_phase_out_four_oe && o_phase_out_three_oe) else $error("pin idle");
  a_all_on: assert property (o_running && i_all_phase_turn_on
    |=> o_phase_out_one && o_phase_out_two) else $error("all-on missed");
  a_idle_quiet: assert property (!o_running |-> !o_phase_out_one
    && !o_phase_out_four) else $error("output before straps latched");
  a_oe_sense: assert property (o_phase_out_four_oe ==
    o_current_sense_en[3] && o_phase_out_three_oe == o_current_sense_en[2])
    else $error("enable and sense mismatch");
  c_all_on: cover property (o_running && i_all_phase_turn_on);
  c_four: cover property (o_running && o_phase_count == 3'h4);
  c_three: cover property (o_running && o_phase_count == 3'h3);
  c_two: cover property (o_running && o_phase_count == 3'h2);
endmodule : mpps_seq_asserts
bind mpps_sequencer mpps_seq_asserts u_chk (.i_clk, .i_rstn,
  .i_all_phase_turn_on, .i_phase_out_three, .i_phase_out_four,
  .o_phase_out_one, .o_phase_out_two, .o_phase_out_four,
  .o_phase_out_three_oe, .o_phase_out_four_oe, .o_current_sense_en,
  .o_phase_count, .o_running);

/* File: verification/mpps_driver_model.sv */
// Driver chip inputs and supply straps on phase pins three and four.
`timescale 1ns/100ps
module mpps_driver_model (
  input  wire logic i_strap_three,
  input  wire logic i_strap_four,
  input  wire logic i_out_three,
  input  wire logic i_out_four,
  input  wire logic i_oe_three,
  input  wire logic i_oe_four,
  output logic      o_pin_three,
  output logic      o_pin_four
);
  // An undriven pin falls to the driver input's weak pull-down.
  assign o_pin_three = i_strap_three | (i_oe_three & i_out_three);
  assign o_pin_four  = i_strap_four | (i_oe_four & i_out_four);
endmodule : mpps_driver_model

/* File: verification/testbench.sv */
// Self-checking bench for the phase sequencer.
`timescale 1ns/100ps
module testbench;
  logic        clk = 0, rstn = 0, all_on = 0, s3 = 0, s4 = 0;
  logic [15:0] per = 0, comp = 0, shift = 0;
  logic        p1, p2, p3, p4, oe3, oe4, run, pin3, pin4;
  logic [3:0]  sen, q;
  logic [2:0]  cnt;
  int          n_fail = 0, comparisons = 0, cyc = 0, r[4], rp[4];
  wire  [3:0]  outs = {p4, p3, p2, p1};
  always #25 clk = ~clk;
  mpps_sequencer dut (.i_clk(clk), .i_rstn(rstn),
    .i_frequency_set_input(per), .i_comp(comp), .i_lead_shift(shift),
    .i_all_phase_turn_on(all_on), .i_phase_out_three(pin3),
    .i_phase_out_four(pin4), .o_phase_out_one(p1), .o_phase_out_two(p2),
    .o_phase_out_three(p3), .o_phase_out_four(p4),
    .o_phase_out_three_oe(oe3), .o_phase_out_four_oe(oe4),
    .o_current_sense_en(sen), .o_phase_count(cnt), .o_running(run));
  mpps_driver_model pm (.i_strap_three(s3), .i_strap_four(s4),
    .i_out_three(p3), .i_out_four(p4), .i_oe_three(oe3), .i_oe_four(oe4),
    .o_pin_three(pin3), .o_pin_four(pin4));
  // Rising edges are logged per phase to measure spacing and period.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    q <= outs;
    for (int i = 0; i < 4; i++) if (outs[i] && !q[i]) begin
      rp[i] <= r[i];
      r[i] <= cyc;
    end
  end
  task chk(input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (e !== g) begin
      n_fail++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  // Phase one is high from ramp count shift up to comp - 1 each period;
  // with no shift the restart itself raises it for at least one cycle.
  function automatic int exp_high(input int c, input int s);
    if (s == 0) return (c == 0) ? 1 : c;
    return (s < c) ? c - s : 0;
  endfunction : exp_high
  task results;
    $display("n_fail=%0d comparisons=%0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  initial begin
    #1000000;
    n_fail++;
    results();
  end
  initial begin
    int n, pe, k, hi;
    void'($urandom(32'h2a4d61b1));
    // Runs three to five use short periods; three must fall back to 20.
    for (int j = 0; j < 6; j++) begin
      {s3, s4} = {j % 3 == 2, j % 3 == 1};
      per = (j < 3) ? 16'(8 + $urandom % 40) : 16'(j);
      pe = (per < 4) ? 20 : int'(per);
      n = 4 - j % 3;
      {comp, shift, all_on} = {16'(pe / 2), 16'h0000, 1'b0};
      rstn = 0;
      repeat (10) @(negedge clk);
      rstn = 1;
      repeat (4 + 3 * pe) @(negedge clk);
      chk(16'(n), 16'(cnt));
      chk(16'(4'hF >> (4 - n)), 16'(sen));
      for (int i = 0; i < n; i++) begin
        chk(16'(pe), 16'(r[i] - rp[i]));
        k = ((r[i] - r[n - 1]) % pe + pe) % pe;
        chk(16'((n - 1 - i) * (pe / n)), 16'(k));
      end
      all_on = 1;
      repeat (2) @(negedge clk);
      chk(16'(4'hF >> (4 - n)), 16'(outs));
      all_on = 0;
      // Each level pair is held two periods, then one full period is
      // counted so that the window starts after a clean restart.
      repeat (4) begin
        comp = 16'($urandom % pe);
        shift = 16'($urandom % 4);
        repeat (2 * pe) @(negedge clk);
        hi = 0;
        repeat (pe) begin
          @(negedge clk);
          hi += int'(p1);
        end
        chk(16'(exp_high(comp, shift)), 16'(hi));
      end
    end
    results();
  end
endmodule : testbench
